// >>> common/hs_negotiator_defs.vh
`ifndef HS_NEGOTIATOR_DEFS_VH
`define HS_NEGOTIATOR_DEFS_VH

// Clock rate and timing
`define CLK_PERIOD_NS      4
`define CLK_HZ             40'h000ee6b280
`define INIT_TIMEOUT_S     40'h000000001e
`define INIT_TIMEOUT_CYC   (`INIT_TIMEOUT_S * `CLK_HZ)
`define SILENT_PERIOD_S    40'h000000003c
`define SILENT_PERIOD_CYC  (`SILENT_PERIOD_S * `CLK_HZ)
`define PROBE_SEG_MS       50
`define PROBE_SEG_CYC      (`PROBE_SEG_MS * (`CLK_HZ / 1000))

// Rate units in kbit/s
`define BASE_RATE_KBPS     64
`define SUB_RATE_KBPS      8
// Margin offset in dB, field in bits 5..1 of the octet
`define MARGIN_OFFSET_DB   6'h0a
`define MARGIN_FIELD_HI    5
`define MARGIN_FIELD_LO    1
// Back-off step in dB per count
`define PBO_STEP_DB        1

// Span limits
`define MAX_REPEATERS      8

// Message codes from the handshake transport
`define MSG_NONE           3'h0
`define MSG_CL             3'h1
`define MSG_MP_PROBE       3'h2
`define MSG_MS             3'h3
`define MSG_ACK1           3'h4
`define MSG_MP_MODE        3'h5
`define MSG_MS_SILENT      3'h6

`endif

// >>> rtl/hs_cycle_timer.v
`timescale 1ns/100ps
module hs_cycle_timer #(
    parameter [39:0] LIMIT = 40'h0000000010
) (
    input  wire        ref_clk_i, // Clock
    input  wire        srst_i,    // Sync reset
    input  wire        run_i,     // Count while high, clear when low
    output wire        expired_o  // Limit reached
);
    reg [39:0] count_reg;
    wire [39:0] count_next;

    assign count_next = !run_i ? 40'h0000000000 :
                        (count_reg == LIMIT) ? count_reg : count_reg + 40'h0000000001;
    assign expired_o  = run_i && (count_reg == LIMIT);

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            count_reg <= 40'h0000000000;
        end else begin
            count_reg <= count_next;
        end
    end
endmodule // hs_cycle_timer

// >>> rtl/handshake_preactivation_negotiator.v
// Summary of operation
// [RULE_01] Open with handshake; rehandshake after probe
// [RULE_02] Known loop skips probe to activation
// [RULE_03] Symmetric rate: base*64k plus sub*8k
// [RULE_04] Asymmetric 2048/2304 masks ignore sub-rate
// [RULE_05] Back-off is one dB per count
// [RULE_06] Probe segment length is count times 50ms
// [RULE_07] Margin is bits 5..1 minus 10dB
// [RULE_08] Send both margins; ignore them in capabilities (code echoes the received octet into both)
// [RULE_09] Low-latency flag forces low-latency encoding
// [RULE_10] Sync and stuff code points set frame bits
// [RULE_11] Silent-period bit forces one-minute silence
// [RULE_12] Half-duplex A4 carrier set is mandatory
// [RULE_13] Far end opens with capabilities or mode
// [RULE_14] Advertise only enabled, current capabilities
// [RULE_15] Changed capabilities force capabilities exchange
// [RULE_16] Far end sends probe MP with downstream parameters
// [RULE_17] Answer probe MP with upstream plus echo
// [RULE_18] After Ack(1) enter line-probe mode
// [RULE_19] Post-probe session advertises loop intersection, back-off
// [RULE_20] Parameter selection ends handshake, starts activation
// [RULE_21] Repeater acts line-side, may send silent selections
// [RULE_22] Advertise intersection with internal link, back-off local
// [RULE_23] Repeater has upstream and downstream halves
// [RULE_24] Up to eight repeaters, X+1 segments
// [RULE_25] Repeater half fails after 30s initiation
// [RULE_26] Negotiated values held stable for activation
`timescale 1ns/100ps
`include "hs_negotiator_defs.vh"
module handshake_preactivation_negotiator #(
    parameter [39:0] INIT_TIMEOUT_CYC  = `INIT_TIMEOUT_CYC,
    parameter [39:0] SILENT_PERIOD_CYC = `SILENT_PERIOD_CYC
) (
    input  wire        ref_clk_i,          // Clock, 250 MHz
    input  wire        srst_i,             // Sync reset, active high
    input  wire        start_i,            // Begin pre-activation
    input  wire        loop_known_i,       // Loop and peer already known
    input  wire        repeater_flag_i,    // Unit is a repeater half
    input  wire        hold_silent_i,      // Repeater must hold far end off
    input  wire [15:0] local_caps_i,       // Local capability bits
    input  wire [15:0] user_enable_i,      // User option enables
    input  wire [15:0] internal_caps_i,    // Caps across internal link
    input  wire [15:0] loop_caps_i,        // Caps found by line probe
    input  wire [5:0]  power_backoff_octet_i, // Desired received back-off
    input  wire [5:0]  up_probe_par_i,     // Upstream probe parameters
    input  wire        probe_done_i,       // Line probe finished
    input  wire        rx_valid_i,         // Received message strobe
    input  wire [2:0]  rx_msg_i,           // Received message code
    input  wire [5:0]  rx_base_rate_i,     // Base rate field
    input  wire [2:0]  rx_sub_rate_i,      // Sub-rate field
    input  wire        rx_asym_mask_i,     // Asymmetric mask selected
    input  wire [5:0]  rx_pbo_i,           // Back-off code point
    input  wire [5:0]  rx_probe_dur_i,     // Probe duration code point
    input  wire [7:0]  rx_margin_octet_i,  // Target margin octet
    input  wire        rx_low_latency_i,   // Low-latency flag
    input  wire [13:0] rx_sync_i,          // Sync word code point
    input  wire [3:0]  rx_stuff_i,         // Stuff bits code point
    input  wire        rx_silent_period_bit_i, // Silent-period bit
    output reg         tx_valid_o,         // Transmit message strobe
    output reg  [2:0]  tx_msg_o,           // Transmit message code
    output reg  [15:0] tx_caps_o,          // Advertised capabilities
    output reg  [5:0]  tx_pbo_o,           // Advertised back-off
    output reg  [11:0] tx_probe_par_o,     // Upstream and echoed downstream
    output reg  [15:0] tx_margin_o,        // Both margin octets
    output wire        carrier_a4_hd_o,    // Half-duplex A4 carrier in use
    output reg         probe_mode_o,       // Line-probe mode active
    output reg         activate_o,         // Activation start, one cycle
    output reg         silent_o,           // Transmitter held silent
    output reg         fail_o,             // Initiation failure, one cycle
    output reg  [11:0] rate_kbps_o,        // Negotiated payload rate
    output reg  [5:0]  pbo_db_o,           // Back-off in dB
    output reg  [29:0] probe_seg_cyc_o,    // Probe segment length in cycles
    output reg  signed [5:0] margin_db_o,  // Target margin in dB
    output reg         low_latency_o,      // Low-latency encoding used
    output reg  [13:0] frame_sync_bits_o,  // Frame sync bits 1..14
    output reg  [3:0]  frame_stuff_bits_o, // Frame stuff bits 1..4
    output reg         params_valid_o      // Negotiated outputs stable
);

    // ****************************************
    // States
    // ****************************************
    localparam [6:0] ST_IDLE   = 7'h01;
    localparam [6:0] ST_SESS1  = 7'h02;
    localparam [6:0] ST_PROBE  = 7'h04;
    localparam [6:0] ST_SESS2  = 7'h08;
    localparam [6:0] ST_ACT    = 7'h10;
    localparam [6:0] ST_SILENT = 7'h20;
    localparam [6:0] ST_WAITACK = 7'h40;

    reg  [6:0]  state_reg;
    reg  [6:0]  state_next;
    reg  [15:0] caps_seen_reg;
    reg         caps_pending_reg;
    reg         got_caps_reg;
    reg  [5:0]  down_probe_reg;
    wire        init_expired;
    wire        silent_expired;
    wire [15:0] adv_caps;
    wire [39:0] rate_full;
    wire [39:0] pbo_full;
    wire [39:0] seg_full;
    wire [5:0]  margin_calc;

    // [RULE_12] fixed carrier set
    assign carrier_a4_hd_o = 1'b1;

    // Full-width products, cut to the output widths where latched
    assign rate_full   = rx_base_rate_i * `BASE_RATE_KBPS +
                         (rx_asym_mask_i ? 40'h0000000000 : rx_sub_rate_i * `SUB_RATE_KBPS);
    assign pbo_full    = rx_pbo_i * `PBO_STEP_DB;
    assign seg_full    = rx_probe_dur_i * `PROBE_SEG_CYC;
    assign margin_calc = {1'b0, rx_margin_octet_i[`MARGIN_FIELD_HI:`MARGIN_FIELD_LO]} - `MARGIN_OFFSET_DB;

    // [RULE_14] [RULE_22] [RULE_19] [RULE_23] advertised intersection
    assign adv_caps = local_caps_i & user_enable_i &
                      (repeater_flag_i ? internal_caps_i : 16'hffff) &
                      ((state_reg == ST_SESS2) ? loop_caps_i : 16'hffff);

    // [RULE_25] initiation timeout
    hs_cycle_timer #(.LIMIT(INIT_TIMEOUT_CYC)) u_init_timer (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .run_i     ((state_reg == ST_SESS1 || state_reg == ST_SESS2) && !got_caps_reg && repeater_flag_i),
        .expired_o (init_expired)
    );

    // [RULE_11] one-minute silence
    hs_cycle_timer #(.LIMIT(SILENT_PERIOD_CYC)) u_silent_timer (
        .ref_clk_i (ref_clk_i),
        .srst_i    (srst_i),
        .run_i     (state_reg == ST_SILENT),
        .expired_o (silent_expired)
    );

    // ****************************************
    // Sequence control
    // ****************************************
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // [RULE_24] one negotiator per segment
                // [RULE_01] session first
                if (start_i) begin
                    state_next = ST_SESS1;
                end
            end
            ST_SESS1, ST_SESS2: begin
                if (init_expired) begin
                    state_next = ST_IDLE;
                end else if (rx_valid_i && rx_silent_period_bit_i) begin
                    state_next = ST_SILENT;
                end else if (rx_valid_i && rx_msg_i == `MSG_MP_PROBE && state_reg == ST_SESS1
                             && !loop_known_i) begin
                    state_next = ST_WAITACK;
                end else if (rx_valid_i && rx_msg_i == `MSG_MP_MODE && !caps_pending_reg
                             && !(repeater_flag_i && hold_silent_i)) begin
                    // [RULE_02] [RULE_20] selection ends handshake
                    state_next = ST_ACT;
                end
            end
            ST_WAITACK: begin
                // [RULE_18] Ack(1) to probe mode
                if (rx_valid_i && rx_msg_i == `MSG_ACK1) begin
                    state_next = ST_PROBE;
                end
            end
            ST_PROBE: begin
                // [RULE_01] second session after probe
                if (probe_done_i) begin
                    state_next = ST_SESS2;
                end
            end
            ST_SILENT: begin
                if (silent_expired) begin
                    state_next = ST_IDLE;
                end
            end
            ST_ACT: begin
                if (start_i) begin
                    state_next = ST_SESS1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg          <= ST_IDLE;
            caps_seen_reg      <= 16'h0000;
            caps_pending_reg   <= 1'b1;
            got_caps_reg       <= 1'b0;
            down_probe_reg     <= 6'h00;
            tx_valid_o         <= 1'b0;
            tx_msg_o           <= `MSG_NONE;
            tx_caps_o          <= 16'h0000;
            tx_pbo_o           <= 6'h00;
            tx_probe_par_o     <= 12'h000;
            tx_margin_o        <= 16'h0000;
            probe_mode_o       <= 1'b0;
            activate_o         <= 1'b0;
            silent_o           <= 1'b0;
            fail_o             <= 1'b0;
            rate_kbps_o        <= 12'h000;
            pbo_db_o           <= 6'h00;
            probe_seg_cyc_o    <= 30'h00000000;
            margin_db_o        <= 6'h00;
            low_latency_o      <= 1'b1;
            frame_sync_bits_o  <= 14'h0000;
            frame_stuff_bits_o <= 4'h0;
            params_valid_o     <= 1'b0;
        end else begin
            state_reg    <= state_next;
            tx_valid_o   <= 1'b0;
            activate_o   <= 1'b0;
            fail_o       <= init_expired;
            probe_mode_o <= (state_next == ST_PROBE);
            silent_o     <= (state_next == ST_SILENT);
            // [RULE_15] changed capabilities force exchange
            if (adv_caps != caps_seen_reg) begin
                caps_pending_reg <= 1'b1;
            end
            if (state_reg != ST_SESS1 && state_reg != ST_SESS2) begin
                got_caps_reg <= 1'b0;
            end
            if (state_next == ST_SESS1 && state_reg != ST_SESS1) begin
                params_valid_o <= 1'b0;
            end
            if (rx_valid_i && (state_reg == ST_SESS1 || state_reg == ST_SESS2)) begin
                got_caps_reg <= 1'b1;
                case (rx_msg_i)
                    `MSG_CL: begin
                        // [RULE_08] send the received margin octet in both margin positions
                        tx_valid_o       <= 1'b1;
                        tx_msg_o         <= `MSG_CL;
                        tx_caps_o        <= adv_caps;
                        tx_margin_o      <= {rx_margin_octet_i, rx_margin_octet_i};
                        // [RULE_19] [RULE_22] local back-off
                        tx_pbo_o         <= power_backoff_octet_i;
                        caps_seen_reg    <= adv_caps;
                        caps_pending_reg <= 1'b0;
                    end
                    `MSG_MP_PROBE: begin
                        // Probe only offered in session 1 without loop knowledge
                        if (state_reg == ST_SESS1 && !loop_known_i) begin
                            // [RULE_17] upstream plus echo
                            tx_valid_o     <= 1'b1;
                            tx_msg_o       <= `MSG_MS;
                            tx_probe_par_o <= {up_probe_par_i, rx_probe_dur_i};
                            down_probe_reg <= rx_probe_dur_i;
                            // [RULE_06] segment length
                            probe_seg_cyc_o <= seg_full[29:0];
                        end
                    end
                    `MSG_MP_MODE: begin
                        tx_valid_o <= 1'b1;
                        // [RULE_21] silent selection instead of mode
                        tx_msg_o   <= (repeater_flag_i && hold_silent_i) ? `MSG_MS_SILENT : `MSG_MS;
                    end
                    default: begin
                        tx_msg_o <= tx_msg_o;
                    end
                endcase
            end
            if (state_next == ST_ACT && state_reg != ST_ACT) begin
                activate_o <= 1'b1;
                // [RULE_26] latch stable outputs
                params_valid_o <= 1'b1;
                // [RULE_03] [RULE_04] payload rate
                rate_kbps_o <= rate_full[11:0];
                // [RULE_05] one dB steps
                pbo_db_o    <= pbo_full[5:0];
                // [RULE_07] margin field minus offset
                margin_db_o <= margin_calc;
                // [RULE_09] low latency selection
                low_latency_o <= rx_low_latency_i;
                // [RULE_10] frame bits
                frame_sync_bits_o  <= rx_sync_i;
                frame_stuff_bits_o <= rx_stuff_i;
            end
        end
    end

endmodule // handshake_preactivation_negotiator

// >>> verification/far_unit_model.sv
`timescale 1ns/100ps
module far_unit_model (
    input  wire        ref_clk_i,   // Clock
    input  wire [49:0] fields_i,    // Fields to send
    output reg         rx_valid_o,  // Message strobe
    output reg  [2:0]  rx_msg_o,    // Message code
    output wire [49:0] rx_fields_o  // Fields on the line
);
    initial begin
        rx_valid_o = 1'b0;
        rx_msg_o = 3'h0;
    end
    // Fields carry meaning only beside the strobe
    assign rx_fields_o = rx_valid_o ? fields_i : ~fields_i;
    // half duplex, one message at a time
    task send(input [2:0] m);
        begin
            @(negedge ref_clk_i);
            rx_valid_o = 1'b1;
            rx_msg_o = m;
            @(negedge ref_clk_i);
            rx_valid_o = 1'b0;
            rx_msg_o = ~m;
        end
    endtask
endmodule // far_unit_model

// >>> verification/hs_negotiator_sva.sv
`timescale 1ns/100ps
`include "hs_negotiator_defs.vh"
module hs_negotiator_sva #(
    parameter [39:0] SILENT_PERIOD_CYC = 40'h32
) (
    input wire        ref_clk_i,
    input wire        srst_i,
    input wire        start_i,
    input wire        repeater_flag_i,
    input wire [5:0]  up_probe_par_i,
    input wire        rx_valid_i,
    input wire [2:0]  rx_msg_i,
    input wire        tx_valid_o,
    input wire [2:0]  tx_msg_o,
    input wire [11:0] tx_probe_par_o,
    input wire [15:0] tx_margin_o,
    input wire        carrier_a4_hd_o,
    input wire        probe_mode_o,
    input wire        activate_o,
    input wire        silent_o,
    input wire        fail_o,
    input wire [11:0] rate_kbps_o,
    input wire        params_valid_o
);
    reg [39:0] sil_cnt_reg;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Length of the current silent stretch
    always @(posedge ref_clk_i) begin
        if (srst_i || !silent_o)
            sil_cnt_reg <= 40'h0;
        else
            sil_cnt_reg <= sil_cnt_reg + 40'h1;
    end
    property p_carrier; carrier_a4_hd_o == 1'b1; endproperty
    a_carrier: assert property (p_carrier) else $error("carrier mode lost");
    property p_act; activate_o |-> params_valid_o ##1 !activate_o; endproperty
    a_act: assert property (p_act) else $error("activate pulse bad");
    property p_hold; params_valid_o && !start_i |=> $stable(rate_kbps_o); endproperty
    a_hold: assert property (p_hold) else $error("params moved");
    property p_echo; tx_valid_o && $past(rx_msg_i) == `MSG_MP_PROBE |->
        tx_msg_o == `MSG_MS && tx_probe_par_o[11:6] == $past(up_probe_par_i); endproperty
    a_echo: assert property (p_echo) else $error("upstream probe par wrong");
    property p_pair; tx_valid_o |-> tx_margin_o[15:8] == tx_margin_o[7:0]; endproperty
    a_pair: assert property (p_pair) else $error("margin octets differ");
    property p_cause; tx_valid_o |-> $past(rx_valid_i); endproperty
    a_cause: assert property (p_cause) else $error("tx without request");
    property p_probe; $rose(probe_mode_o) |-> $past(rx_valid_i) && $past(rx_msg_i) == `MSG_ACK1; endproperty
    a_probe: assert property (p_probe) else $error("probe mode without ack");
    property p_fail; fail_o |-> repeater_flag_i ##1 !fail_o; endproperty
    a_fail: assert property (p_fail) else $error("fail pulse bad");
    property p_silent; $fell(silent_o) |-> sil_cnt_reg + 40'h1 >= SILENT_PERIOD_CYC &&
        sil_cnt_reg <= SILENT_PERIOD_CYC + 40'h1; endproperty
    a_silent: assert property (p_silent) else $error("silent length wrong");
endmodule // hs_negotiator_sva
bind handshake_preactivation_negotiator hs_negotiator_sva #(.SILENT_PERIOD_CYC(SILENT_PERIOD_CYC)) u_sva (
    .ref_clk_i, .srst_i, .start_i, .repeater_flag_i, .up_probe_par_i, .rx_valid_i, .rx_msg_i,
    .tx_valid_o, .tx_msg_o, .tx_probe_par_o, .tx_margin_o, .carrier_a4_hd_o, .probe_mode_o,
    .activate_o, .silent_o, .fail_o, .rate_kbps_o, .params_valid_o);

// >>> verification/testbench.sv
`timescale 1ns/100ps
`include "hs_negotiator_defs.vh"
module testbench;
    typedef struct packed {
        logic [5:0] base; logic [2:0] sub; logic asym; logic [5:0] power_backoff_octet; logic [7:0] mgn;
        logic [13:0] sync; logic [3:0] stuff; logic [11:0] rate; logic [5:0] mdb;
    } row_t;
    row_t       rows [5];
    reg         clk = 1'b0, srst = 1'b1, start = 1'b0, known = 1'b0;
    reg         rep = 1'b0, hold = 1'b0, pdone = 1'b0;
    reg  [5:0]  bo = 6'h0a, upp = 6'h2d;
    reg  [15:0] ucaps = 16'h3cff;
    reg  [49:0] fields = 50'h0;
    wire [49:0] rxf;
    wire [2:0]  rxm, txm;
    wire        rxv, txv, act, pmode, sil, fail, lowlat, pval;
    wire [15:0] txc;
    wire [11:0] txpp, rate;
    wire [5:0]  pbodb, mdb, txpb;
    wire [29:0] pseg;
    wire [13:0] fsync;
    wire [3:0]  fstuff;
    int         fail_count = 0, checks_done = 0, i;
    always #2 clk = ~clk;
    far_unit_model i_far (.ref_clk_i(clk), .fields_i(fields), .rx_valid_o(rxv), .rx_msg_o(rxm), .rx_fields_o(rxf));
    handshake_preactivation_negotiator #(.INIT_TIMEOUT_CYC(40'h64), .SILENT_PERIOD_CYC(40'h32)) i_dut (
        .ref_clk_i(clk), .srst_i(srst), .start_i(start), .loop_known_i(known),
        .repeater_flag_i(rep), .hold_silent_i(hold), .local_caps_i(16'hf0f3), .user_enable_i(ucaps),
        .internal_caps_i(16'h0ff0), .loop_caps_i(16'h5555), .power_backoff_octet_i(bo),
        .up_probe_par_i(upp), .probe_done_i(pdone), .rx_valid_i(rxv), .rx_msg_i(rxm),
        .rx_base_rate_i(rxf[49:44]), .rx_sub_rate_i(rxf[43:41]), .rx_asym_mask_i(rxf[40]),
        .rx_pbo_i(rxf[39:34]), .rx_probe_dur_i(rxf[33:28]), .rx_margin_octet_i(rxf[27:20]),
        .rx_low_latency_i(rxf[19]), .rx_sync_i(rxf[18:5]), .rx_stuff_i(rxf[4:1]),
        .rx_silent_period_bit_i(rxf[0]), .tx_valid_o(txv), .tx_msg_o(txm), .tx_caps_o(txc),
        .tx_pbo_o(txpb), .tx_probe_par_o(txpp), .tx_margin_o(), .carrier_a4_hd_o(),
        .probe_mode_o(pmode), .activate_o(act), .silent_o(sil), .fail_o(fail), .rate_kbps_o(rate),
        .pbo_db_o(pbodb), .probe_seg_cyc_o(pseg), .margin_db_o(mdb), .low_latency_o(lowlat),
        .frame_sync_bits_o(fsync), .frame_stuff_bits_o(fstuff), .params_valid_o(pval));
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checks_done, fail_count);
            if (fail_count == 0 && checks_done > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input string n, input [29:0] e, input [29:0] g);
        begin
            checks_done++;
            if (g !== e) begin
                fail_count++;
                $display("Error %s exp %h got %h", n, e, g);
            end
        end
    endtask
    function bit sig(input int s);
        case (s)
            0: sig = txv === 1'b1;
            1: sig = act === 1'b1;
            2: sig = pmode === 1'b1;
            3: sig = sil === 1'b1;
            4: sig = fail === 1'b1;
            default: sig = sil === 1'b0;
        endcase
    endfunction
    // Bounded wait; none set means the event must not come
    task wt(input int s, input int lim, input bit none);
        int k;
        bit hit;
        begin
            hit = sig(s);
            for (k = 0; k < lim && !hit; k++) begin
                @(negedge clk);
                hit = sig(s);
            end
            checks_done++;
            if (hit == none) begin
                fail_count++;
                $display("Error wait%0d exp %0d got %0d", s, !none, hit);
                if (!none)
                    report_and_stop;
            end
        end
    endtask
    task go;
        begin
            @(negedge clk);
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
        end
    endtask
    task cl(input [15:0] caps);
        begin
            i_far.send(`MSG_CL);
            wt(0, 4, 1'b0);
            chk("tx_msg", `MSG_CL, txm);
            chk("tx_caps", caps, txc);
            chk("tx_pbo", bo, txpb);
        end
    endtask
    task mode(input bit ok);
        begin
            i_far.send(`MSG_MP_MODE);
            wt(1, 4, !ok);
        end
    endtask
    initial begin
        rows[0] = '{6'h01, 3'h0, 1'b0, 6'h00, 8'h00, 14'h0001, 4'h1, 12'h040, 6'h36};
        rows[1] = '{6'h24, 3'h7, 1'b0, 6'h3f, 8'h3f, 14'h2aaa, 4'ha, 12'h938, 6'h15};
        rows[2] = '{6'h20, 3'h5, 1'b1, 6'h05, 8'h00, 14'h1555, 4'h5, 12'h800, 6'h36};
        rows[3] = '{6'h3f, 3'h7, 1'b0, 6'h01, 8'h3f, 14'h3fff, 4'hf, 12'hff8, 6'h15};
        rows[4] = '{6'h24, 3'h3, 1'b1, 6'h20, 8'h00, 14'h0000, 4'h0, 12'h900, 6'h36};
        repeat (20) @(negedge clk);
        srst = 1'b0;
        chk("low_lat", 1, lowlat);
        chk("params", 0, pval);
        go;
        mode(1'b0);
        for (i = 0; i < 5; i++) begin
            fields = {rows[i].base, rows[i].sub, rows[i].asym, rows[i].power_backoff_octet, 6'h01, rows[i].mgn,
                      1'b1, rows[i].sync, rows[i].stuff, 1'b0};
            go;
            cl(16'h30f3);
            mode(1'b1);
            chk("rate", rows[i].rate, rate);
            chk("pbo_db", rows[i].power_backoff_octet, pbodb);
            chk("margin", rows[i].mdb, mdb);
            chk("sync", rows[i].sync, fsync);
            chk("stuff", rows[i].stuff, fstuff);
            chk("low_lat", 1, lowlat);
            chk("params", 1, pval);
        end
        fields[19] = 1'b0;
        go;
        mode(1'b1);
        chk("low_lat", 0, lowlat);
        ucaps = 16'h3cfe;
        go;
        mode(1'b0);
        cl(16'h30f2);
        mode(1'b1);
        go;
        cl(16'h30f2);
        i_far.send(`MSG_MP_PROBE);
        wt(0, 4, 1'b0);
        chk("ms", `MSG_MS, txm);
        chk("up_par", 6'h2d, txpp[11:6]);
        chk("echo", 6'h01, txpp[5:0]);
        chk("seg", 30'h00bebc20, pseg);
        i_far.send(`MSG_ACK1);
        wt(2, 4, 1'b0);
        pdone = 1'b1;
        @(negedge clk);
        pdone = 1'b0;
        bo = 6'h15;
        cl(16'h1050);
        mode(1'b1);
        known = 1'b1;
        go;
        cl(16'h30f2);
        i_far.send(`MSG_MP_PROBE);
        wt(0, 4, 1'b1);
        mode(1'b1);
        known = 1'b0;
        rep = 1'b1;
        go;
        wt(4, 120, 1'b0);
        go;
        cl(16'h00f0);
        hold = 1'b1;
        i_far.send(`MSG_MP_MODE);
        wt(0, 4, 1'b0);
        chk("silent_ms", `MSG_MS_SILENT, txm);
        chk("act", 0, act);
        hold = 1'b0;
        rep = 1'b0;
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        fields[0] = 1'b1;
        go;
        i_far.send(`MSG_CL);
        wt(3, 8, 1'b0);
        wt(5, 80, 1'b0);
        report_and_stop;
    end
endmodule // testbench
